// ### logic/ptm_pin_control.sv
// Port T output steering and port M pull / open-drain control, APB slave

module ptm_pin_control #(
   parameter int PT_WIDTH  = ptm_pkg::PTM_PT_WIDTH,
   parameter int PM_WIDTH  = ptm_pkg::PTM_PM_WIDTH,
   parameter int PWM_WIDTH = ptm_pkg::PTM_PWM_WIDTH
) (
   input  wire logic                 REF_CLK,
   input  wire logic                 RESET_N,
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire logic [7:0]           PADDR,
   input  wire logic [31:0]          PWDATA,
   output logic      [31:0]          PRDATA,
   output logic                      PREADY,
   output logic                      PSLVERR,
   input  wire logic                 TIM_ENABLE,
   input  wire logic [PT_WIDTH-1:0]  TIM_DIR_SEL,
   input  wire logic [PT_WIDTH-1:0]  TIM_TOV_SEL,
   input  wire logic [2*PT_WIDTH-1:0] TIM_ACTION_CTL,
   input  wire logic [PT_WIDTH-1:0]  TIM_COMPARE_OUT,
   input  wire logic [PWM_WIDTH-1:0] PWM_CHANNEL_ENABLE,
   input  wire logic [PWM_WIDTH-1:0] PWM_CHANNEL_OUT,
   input  wire logic [PT_WIDTH-1:0]  PT_IN,
   output logic      [PT_WIDTH-1:0]  PT_OUT,
   output logic      [PT_WIDTH-1:0]  PT_OE,
   input  wire logic [PM_WIDTH-1:0]  PM_IN,
   output logic      [PM_WIDTH-1:0]  PM_OUT,
   output logic      [PM_WIDTH-1:0]  PM_OE,
   output logic      [PM_WIDTH-1:0]  PM_PULL_UP,
   output logic      [PM_WIDTH-1:0]  PM_PULL_DOWN
);

   if (PT_WIDTH > ptm_pkg::PTM_REG_WIDTH || PM_WIDTH > ptm_pkg::PTM_REG_WIDTH
       || PWM_WIDTH > PT_WIDTH || PWM_WIDTH < 1 || PM_WIDTH < 1)
   begin : g_param_check
      $error("ptm_pin_control: port widths out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [PT_WIDTH-1:0]  pt_data_r;
   logic [PT_WIDTH-1:0]  pt_dir_r;
   logic [PWM_WIDTH-1:0] routing_r;
   logic [PM_WIDTH-1:0]  pm_data_r;
   logic [PM_WIDTH-1:0]  pm_dir_r;
   logic [PM_WIDTH-1:0]  pm_pull_en_r;
   logic [PM_WIDTH-1:0]  pm_polarity_r;
   logic [PM_WIDTH-1:0]  pm_open_drain_r;
   logic [31:0]          prdata_r;
   logic                 pready_r;
   logic                 pslverr_r;
   logic [PT_WIDTH-1:0]  pt_out_r;
   logic [PT_WIDTH-1:0]  pt_oe_r;
   logic [PM_WIDTH-1:0]  pm_out_r;
   logic [PM_WIDTH-1:0]  pm_oe_r;
   logic [PM_WIDTH-1:0]  pm_pull_up_r;
   logic [PM_WIDTH-1:0]  pm_pull_down_r;

   logic [PT_WIDTH-1:0]  pt_in_s;
   logic [PM_WIDTH-1:0]  pm_in_s;
   logic                 setup_w;
   logic                 access_done_w;
   logic                 wr_go_w;
   logic                 unmapped_w;
   logic [31:0]          rd_word_w;
   logic [PT_WIDTH-1:0]  pt_read_w;
   logic [PM_WIDTH-1:0]  pm_read_w;
   logic [PT_WIDTH-1:0]  tim_active_w;
   logic [PT_WIDTH-1:0]  pwm_sel_w;
   logic [PT_WIDTH-1:0]  pwm_out_w;
   logic [PT_WIDTH-1:0]  pt_out_nxt;
   logic [PT_WIDTH-1:0]  pt_oe_nxt;
   logic [PM_WIDTH-1:0]  pm_oe_nxt;
   logic [PM_WIDTH-1:0]  pm_pull_up_nxt;
   logic [PM_WIDTH-1:0]  pm_pull_down_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Address match and routing of a timer action field onto the pin
   function automatic logic hit(input logic [7:0] addr,
                                input logic [5:0] idx);
      hit = (addr == ptm_pkg::ptm_addr(idx));
   endfunction

   function automatic logic [PT_WIDTH-1:0] tim_routed(
      input logic [2*PT_WIDTH-1:0] ctl);
      logic [PT_WIDTH-1:0] res;
      res = '0;
      for (int i = 0; i < PT_WIDTH; i++) begin
         res[i] = |ctl[2*i +: 2];
      end
      tim_routed = res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   ptm_pin_sync #(.WIDTH(PT_WIDTH)) u_pt_sync (
      .clk       (REF_CLK),
      .rst_n     (RESET_N),
      .pin_async (PT_IN),
      .pin_sync  (pt_in_s)
   );

   ptm_pin_sync #(.WIDTH(PM_WIDTH)) u_pm_sync (
      .clk       (REF_CLK),
      .rst_n     (RESET_N),
      .pin_async (PM_IN),
      .pin_sync  (pm_in_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // APB decode; no wait state, read data is captured in a flop during the setup cycle
   assign setup_w       = PSEL & ~PENABLE;
   assign access_done_w = PSEL & PENABLE & pready_r;
   assign unmapped_w    = ~(hit(PADDR, ptm_pkg::PTM_IDX_PT_DATA)
                          | hit(PADDR, ptm_pkg::PTM_IDX_PT_DIRECTION)
                          | hit(PADDR, ptm_pkg::PTM_IDX_ROUTING)
                          | hit(PADDR, ptm_pkg::PTM_IDX_PM_DATA)
                          | hit(PADDR, ptm_pkg::PTM_IDX_PM_DIRECTION)
                          | hit(PADDR, ptm_pkg::PTM_IDX_PM_PULL_ENABLE)
                          | hit(PADDR, ptm_pkg::PTM_IDX_PM_POLARITY)
                          | hit(PADDR, ptm_pkg::PTM_IDX_PM_OPEN_DRAIN));
   assign wr_go_w       = access_done_w & PWRITE & ~unmapped_w;

   assign pt_read_w = (pt_dir_r & pt_data_r) | (~pt_dir_r & pt_in_s);
   assign pm_read_w = (pm_dir_r & pm_data_r) | (~pm_dir_r & pm_in_s);

   // Narrow registers zero-extend, so unused upper bits read as zero
   assign rd_word_w =
      hit(PADDR, ptm_pkg::PTM_IDX_PT_DATA)        ? 32'(pt_read_w) :
      hit(PADDR, ptm_pkg::PTM_IDX_PT_DIRECTION)   ? 32'(pt_dir_r) :
      hit(PADDR, ptm_pkg::PTM_IDX_ROUTING)        ? 32'(routing_r) :
      hit(PADDR, ptm_pkg::PTM_IDX_PM_DATA)        ? 32'(pm_read_w) :
      hit(PADDR, ptm_pkg::PTM_IDX_PM_DIRECTION)   ? 32'(pm_dir_r) :
      hit(PADDR, ptm_pkg::PTM_IDX_PM_PULL_ENABLE) ? 32'(pm_pull_en_r) :
      hit(PADDR, ptm_pkg::PTM_IDX_PM_POLARITY)    ? 32'(pm_polarity_r) :
      hit(PADDR, ptm_pkg::PTM_IDX_PM_OPEN_DRAIN)  ? 32'(pm_open_drain_r) :
      32'h0000_0000;

   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= setup_w;
         pslverr_r <= setup_w & unmapped_w;
         prdata_r  <= (setup_w & ~PWRITE) ? rd_word_w : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         pt_data_r       <= PT_WIDTH'(ptm_pkg::PTM_RST_PT_DATA);
         pt_dir_r        <= PT_WIDTH'(ptm_pkg::PTM_RST_PT_DIRECTION);
         routing_r       <= PWM_WIDTH'(ptm_pkg::PTM_RST_ROUTING);
         pm_data_r       <= PM_WIDTH'(ptm_pkg::PTM_RST_PM_DATA);
         pm_dir_r        <= PM_WIDTH'(ptm_pkg::PTM_RST_PM_DIRECTION);
         pm_pull_en_r    <= PM_WIDTH'(ptm_pkg::PTM_RST_PM_PULL_EN);
         pm_polarity_r   <= PM_WIDTH'(ptm_pkg::PTM_RST_PM_POLARITY);
         pm_open_drain_r <= PM_WIDTH'(ptm_pkg::PTM_RST_PM_OPEN_DRN);
      end else if (wr_go_w) begin
         if (hit(PADDR, ptm_pkg::PTM_IDX_PT_DATA))
            pt_data_r <= PWDATA[ptm_pkg::PTM_PWDATA_LSB +: PT_WIDTH];
         if (hit(PADDR, ptm_pkg::PTM_IDX_PT_DIRECTION))
            pt_dir_r <= PWDATA[ptm_pkg::PTM_PWDATA_LSB +: PT_WIDTH];
         if (hit(PADDR, ptm_pkg::PTM_IDX_ROUTING))
            routing_r <= PWDATA[ptm_pkg::PTM_PWDATA_LSB +: PWM_WIDTH];
         if (hit(PADDR, ptm_pkg::PTM_IDX_PM_DATA))
            pm_data_r <= PWDATA[ptm_pkg::PTM_PWDATA_LSB +: PM_WIDTH];
         if (hit(PADDR, ptm_pkg::PTM_IDX_PM_DIRECTION))
            pm_dir_r <= PWDATA[ptm_pkg::PTM_PWDATA_LSB +: PM_WIDTH];
         if (hit(PADDR, ptm_pkg::PTM_IDX_PM_PULL_ENABLE))
            pm_pull_en_r <= PWDATA[ptm_pkg::PTM_PWDATA_LSB +: PM_WIDTH];
         if (hit(PADDR, ptm_pkg::PTM_IDX_PM_POLARITY))
            pm_polarity_r <= PWDATA[ptm_pkg::PTM_PWDATA_LSB +: PM_WIDTH];
         if (hit(PADDR, ptm_pkg::PTM_IDX_PM_OPEN_DRAIN))
            pm_open_drain_r <= PWDATA[ptm_pkg::PTM_PWDATA_LSB +: PM_WIDTH];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port T source selection
   assign tim_active_w = {PT_WIDTH{TIM_ENABLE}}
                       & (TIM_DIR_SEL | TIM_TOV_SEL)
                       & tim_routed(TIM_ACTION_CTL);
   assign pwm_sel_w    = PT_WIDTH'(routing_r & PWM_CHANNEL_ENABLE);
   assign pwm_out_w    = PT_WIDTH'(PWM_CHANNEL_OUT);

   // Pulse wins over timer, timer over general I/O
   assign pt_out_nxt = (pwm_sel_w & pwm_out_w)
                     | (~pwm_sel_w & tim_active_w & TIM_COMPARE_OUT)
                     | (~pwm_sel_w & ~tim_active_w & pt_data_r);
   assign pt_oe_nxt  = pwm_sel_w | tim_active_w | pt_dir_r;

   ////////////////////////////////////////////////////////////////////////
   // Port M pull and drive mode
   // A wired-OR pin drives only the low level; a one is left to the pull-up
   assign pm_oe_nxt = pm_dir_r & (~pm_open_drain_r | ~pm_data_r);
   assign pm_pull_up_nxt = pm_pull_en_r & ~pm_polarity_r
                         & (~pm_dir_r | pm_open_drain_r);
   assign pm_pull_down_nxt = pm_pull_en_r & pm_polarity_r
                           & ~pm_dir_r;

   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         pt_out_r       <= '0;
         pt_oe_r        <= '0;
         pm_out_r       <= '0;
         pm_oe_r        <= '0;
         pm_pull_up_r   <= '0;
         pm_pull_down_r <= '0;
      end else begin
         pt_out_r       <= pt_out_nxt;
         pt_oe_r        <= pt_oe_nxt;
         pm_out_r       <= pm_data_r & ~pm_open_drain_r;
         pm_oe_r        <= pm_oe_nxt;
         pm_pull_up_r   <= pm_pull_up_nxt;
         pm_pull_down_r <= pm_pull_down_nxt;
      end
   end

   assign PRDATA       = prdata_r;
   assign PREADY       = pready_r;
   assign PSLVERR      = pslverr_r;
   assign PT_OUT       = pt_out_r;
   assign PT_OE        = pt_oe_r;
   assign PM_OUT       = pm_out_r;
   assign PM_OE        = pm_oe_r;
   assign PM_PULL_UP   = pm_pull_up_r;
   assign PM_PULL_DOWN = pm_pull_down_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   sequence s_wr_setup(logic [5:0] idx);
      PSEL && !PENABLE && PWRITE && PADDR == ptm_pkg::ptm_addr(idx);
   endsequence

   sequence s_wr_access;
      PSEL && PENABLE && PREADY;
   endsequence

   chk_ptt_read_mix: assert property (
      PSEL && !PENABLE && !PWRITE
      && PADDR == ptm_pkg::ptm_addr(ptm_pkg::PTM_IDX_PT_DATA)
      |=> PRDATA == 32'((($past(pt_dir_r) & $past(pt_data_r))
                    | (~$past(pt_dir_r) & $past(pt_in_s)))))
      else $error("port T read data wrong");

   chk_timer_takes_pin: assert property (
      tim_active_w != '0 |=> (PT_OE & $past(tim_active_w))
                             == $past(tim_active_w))
      else $error("active timer pin not driven");

   chk_route_only: assert property (
      routing_r == '0 |=> ((PT_OUT ^ $past(TIM_COMPARE_OUT))
                          & $past(tim_active_w)) == '0)
      else $error("pulse output reached pin without routing");

   chk_pulse_priority: assert property (
      pwm_sel_w != '0 |=> ((PT_OUT ^ $past(pwm_out_w))
                          & $past(pwm_sel_w)) == '0)
      else $error("routed pulse output lost priority");

   chk_timer_disabled: assert property (
      !TIM_ENABLE && pwm_sel_w == '0
      |=> PT_OE == $past(pt_dir_r) && PT_OUT == $past(pt_data_r))
      else $error("disabled timer still steers port T");

   chk_pull_polarity: assert property (
      ##1 (PM_PULL_UP & $past(pm_polarity_r)) == '0
      && (PM_PULL_DOWN & ~$past(pm_polarity_r)) == '0)
      else $error("pull device against polarity");

   chk_pull_up_gate: assert property (
      ##1 (PM_PULL_UP & ~$past(pm_pull_en_r)) == '0
      && (PM_PULL_UP & $past(pm_dir_r) & ~$past(pm_open_drain_r)) == '0)
      else $error("pull-up on push-pull output or disabled pin");

   chk_pull_down_gate: assert property (
      (PM_PULL_DOWN & PM_OE) == '0)
      else $error("pull-down while pin is driven");

   chk_open_drain_one: assert property (
      ##1 (PM_OE & $past(pm_open_drain_r) & $past(pm_data_r)) == '0
      && (PM_OUT & $past(pm_open_drain_r)) == '0)
      else $error("wired-OR pin drove a one");

   chk_wom_input: assert property (
      ##1 (PM_OE & ~$past(pm_dir_r)) == '0)
      else $error("input pin driven");

   chk_push_pull: assert property (
      ##1 (~PM_OE & $past(pm_dir_r) & ~$past(pm_open_drain_r)) == '0)
      else $error("push-pull output not driven");

   chk_ptt_reset: assert property (
      @(posedge REF_CLK) disable iff (1'b0)
      !RESET_N |=> pt_data_r == '0 && PT_OUT == '0)
      else $error("port T data not cleared by reset");

   chk_wom_write: assert property (
      s_wr_setup(ptm_pkg::PTM_IDX_PM_OPEN_DRAIN) ##1 s_wr_access
      |=> pm_open_drain_r == $past(PWDATA[PM_WIDTH-1:0]))
      else $error("wired-OR register write lost");

endmodule // ptm_pin_control

// ### logic/ptm_pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels
module ptm_pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin_async,
   output logic      [WIDTH-1:0] pin_sync
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   if (WIDTH < 1) begin : g_width_check
      $error("ptm_pin_sync: WIDTH must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////
   // First stage is read only by the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pin_async;
         sync_r <= meta_r;
      end
   end

   assign pin_sync = sync_r;

endmodule // ptm_pin_sync

// ### pkg/ptm_pkg.sv
// Shared constants for the port T / port M pin control block
package ptm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [5:0] PTM_IDX_PT_DATA        = 6'h00;
   localparam logic [5:0] PTM_IDX_PT_DIRECTION   = 6'h02;
   localparam logic [5:0] PTM_IDX_ROUTING        = 6'h07;
   localparam logic [5:0] PTM_IDX_PM_DATA        = 6'h10;
   localparam logic [5:0] PTM_IDX_PM_DIRECTION   = 6'h12;
   localparam logic [5:0] PTM_IDX_PM_PULL_ENABLE = 6'h14;
   localparam logic [5:0] PTM_IDX_PM_POLARITY    = 6'h15;
   localparam logic [5:0] PTM_IDX_PM_OPEN_DRAIN  = 6'h16;

   ////////////////////////////////////////////////////////////////////////
   // Widths of the ports and of the routed pulse channels
   localparam int PTM_PT_WIDTH  = 8;
   localparam int PTM_PM_WIDTH  = 6;
   localparam int PTM_PWM_WIDTH = 5;
   localparam int PTM_REG_WIDTH = 8;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int PTM_PWDATA_LSB = 0;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] PTM_RST_PT_DATA      = 8'h00;
   localparam logic [7:0] PTM_RST_PT_DIRECTION = 8'h00;
   localparam logic [7:0] PTM_RST_ROUTING      = 8'h00;
   localparam logic [7:0] PTM_RST_PM_DATA      = 8'h00;
   localparam logic [7:0] PTM_RST_PM_DIRECTION = 8'h00;
   localparam logic [7:0] PTM_RST_PM_PULL_EN   = 8'h00;
   localparam logic [7:0] PTM_RST_PM_POLARITY  = 8'h00;
   localparam logic [7:0] PTM_RST_PM_OPEN_DRN  = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Synchroniser depth for pin inputs
   localparam int PTM_SYNC_STAGES = 2;

   // Byte address of a register index
   function automatic logic [7:0] ptm_addr(input logic [5:0] idx);
      ptm_addr = {idx, 2'b00};
   endfunction

endpackage

// ### testbench/ptm_board_model.sv
// Board circuitry model that resolves port T and port M pin levels
module ptm_board_model (
   input  wire logic       clk,
   input  wire logic [7:0] pt_out,
   input  wire logic [7:0] pt_oe,
   input  wire logic [7:0] ext_pt_val,
   input  wire logic [7:0] ext_pt_en,
   input  wire logic [5:0] pm_out,
   input  wire logic [5:0] pm_oe,
   input  wire logic [5:0] pm_pu,
   input  wire logic [5:0] pm_pd,
   input  wire logic [5:0] ext_pm_val,
   input  wire logic [5:0] ext_pm_en,
   output logic      [7:0] pt_in,
   output logic      [5:0] pm_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pt_r = 8'h00;
   logic [5:0] pm_r = 6'h00;
   ////////////////////////////////////////////////////////////////////////
   // A floating line flips every cycle so a stale level never passes
   always @(posedge clk) begin
      pt_r <= pt_in;
      pm_r <= pm_in;
   end
   assign pt_in = (pt_oe & pt_out) | (~pt_oe & ext_pt_en & ext_pt_val)
                | (~pt_oe & ~ext_pt_en & ~pt_r);
   // Pull devices decide the level only when nobody drives the pin
   wire [5:0] pm_free = ~pm_oe & ~ext_pm_en;
   assign pm_in = (pm_oe & pm_out) | (~pm_oe & ext_pm_en & ext_pm_val)
                | (pm_free & pm_pu)
                | (pm_free & ~pm_pu & ~pm_pd & ~pm_r);
endmodule // ptm_board_model

// ### testbench/tb_ptm_pin_control.sv
// Self-checking testbench for the port T / port M pin control block
module tb_ptm_pin_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] a_ptd = {ptm_pkg::PTM_IDX_PT_DATA, 2'b00};
   localparam logic [7:0] a_ptr = {ptm_pkg::PTM_IDX_PT_DIRECTION, 2'b00};
   localparam logic [7:0] a_rt  = {ptm_pkg::PTM_IDX_ROUTING, 2'b00};
   localparam logic [7:0] a_pmd = {ptm_pkg::PTM_IDX_PM_DATA, 2'b00};
   localparam logic [7:0] a_pmr = {ptm_pkg::PTM_IDX_PM_DIRECTION, 2'b00};
   localparam logic [7:0] a_pe  = {ptm_pkg::PTM_IDX_PM_PULL_ENABLE, 2'b00};
   localparam logic [7:0] a_pol = {ptm_pkg::PTM_IDX_PM_POLARITY, 2'b00};
   localparam logic [7:0] a_od  = {ptm_pkg::PTM_IDX_PM_OPEN_DRAIN, 2'b00};
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, tim_en;
   logic [7:0]  paddr, tim_dir, tim_tov, tim_cmp, pt_in, pt_out, pt_oe;
   logic [7:0]  ext_pt_val, ext_pt_en;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] tim_act;
   logic [4:0]  pwm_en, pwm_out, c;
   logic [5:0]  pm_in, pm_out, pm_oe, pm_pu, pm_pd, ext_pm_val, ext_pm_en;
   logic        e, d, w, p, s, v;
   int          err_count, comparisons, i;

   ptm_pin_control ptm_pin_control_i (.REF_CLK(clk), .RESET_N(rst_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TIM_ENABLE(tim_en), .TIM_DIR_SEL(tim_dir), .TIM_TOV_SEL(tim_tov),
      .TIM_ACTION_CTL(tim_act), .TIM_COMPARE_OUT(tim_cmp),
      .PWM_CHANNEL_ENABLE(pwm_en), .PWM_CHANNEL_OUT(pwm_out),
      .PT_IN(pt_in), .PT_OUT(pt_out), .PT_OE(pt_oe), .PM_IN(pm_in),
      .PM_OUT(pm_out), .PM_OE(pm_oe), .PM_PULL_UP(pm_pu),
      .PM_PULL_DOWN(pm_pd));
   ptm_board_model ptm_board_model_i (.clk(clk), .pt_out(pt_out),
      .pt_oe(pt_oe), .ext_pt_val(ext_pt_val), .ext_pt_en(ext_pt_en),
      .pm_out(pm_out), .pm_oe(pm_oe), .pm_pu(pm_pu), .pm_pd(pm_pd),
      .ext_pm_val(ext_pm_val), .ext_pm_en(ext_pm_en), .pt_in(pt_in),
      .pm_in(pm_in));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Holds the request until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] dat);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      @(posedge clk);
      penable <= 1'b1;
      // A missing answer is left to the watchdog
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check(nm, q, exp);
      check({nm, "_err"}, 32'(e), 32'h00000000);
   endtask

   task automatic end_test(input string nm);
      $display("test %s done", nm);
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Whole run needs about 900 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      test_done;
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, psel, penable, pwrite, tim_en} = 5'h00;
      // Board holds port T low until the tests release the pins
      {paddr, tim_dir, tim_tov, tim_cmp, ext_pt_val, ext_pt_en} =
         48'h0000_0000_00ff;
      {pwdata, tim_act, pwm_en, pwm_out} = 58'h0;
      {ext_pm_val, ext_pm_en} = 12'h000;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("pt_oe_rst", 32'(pt_oe), 32'h00000000);
      rdc("pt_data_rst", a_ptd, 32'h00000000);
      apb(1'b1, a_ptr, 32'h000000ff);
      rdc("pt_data_rst_reg", a_ptd, 32'h00000000);
      rdc("polarity_rst", a_pol, 32'h00000000);
      rdc("open_drain_rst", a_od, 32'h00000000);
      apb(1'b1, a_pol, 32'hffffffff);
      rdc("polarity_rw", a_pol, 32'h0000003f);
      apb(1'b1, a_od, 32'h000000ff);
      rdc("open_drain_rw", a_od, 32'h0000003f);
      apb(1'b1, 8'hfc, 32'h00000055);
      check("unmapped_wr_err", 32'(e), 32'h00000001);
      apb(1'b0, 8'hfc, 32'h00000000);
      check("unmapped_rd_err", 32'(e), 32'h00000001);
      check("unmapped_rd", q, 32'h00000000);
      end_test("registers");
      apb(1'b1, a_ptr, 32'h0000000f);
      apb(1'b1, a_ptd, 32'h000000a5);
      ext_pt_en <= 8'hf0;
      ext_pt_val <= 8'h3c;
      repeat (6) @(posedge clk);
      rdc("pt_data_mixed", a_ptd, 32'h00000035);
      check("pt_oe_gpio", 32'(pt_oe), 32'h0000000f);
      check("pt_out_gpio", 32'(pt_out & 8'h0f), 32'h00000005);
      apb(1'b1, a_ptd, 32'h0000005a);
      rdc("pt_data_rewrite", a_ptd, 32'h0000003a);
      ext_pt_en <= 8'h00;
      apb(1'b1, a_ptr, 32'h00000000);
      apb(1'b1, a_ptd, 32'h00000000);
      end_test("port_t_read");
      // Timer output on pin 1: enable, compare, toggle and routing
      tim_cmp <= 8'h02;
      for (i = 0; i < 16; i++) begin
         c = 5'(i);
         tim_en <= c[3];
         tim_dir <= c[2] ? 8'h02 : 8'h00;
         tim_tov <= c[1] ? 8'h02 : 8'h00;
         tim_act <= c[0] ? 16'h0008 : 16'h0000;
         repeat (3) @(posedge clk);
         v = c[3] & (c[2] | c[1]) & c[0];
         check("timer_oe", 32'(pt_oe[1]), 32'(v));
         check("timer_out", 32'(pt_out[1]), 32'(v));
      end
      end_test("timer_select");
      // Pulse channel 1 against timer channel 1 on pin 1
      tim_dir <= 8'h02;
      tim_tov <= 8'h00;
      tim_act <= 16'h0008;
      for (i = 0; i < 16; i++) begin
         c = 5'(i);
         apb(1'b1, a_rt, c[2] ? 32'h00000002 : 32'h00000000);
         pwm_en <= c[1] ? 5'h02 : 5'h00;
         pwm_out <= c[3] ? 5'h02 : 5'h00;
         tim_en <= c[0];
         repeat (3) @(posedge clk);
         v = c[2] & c[1];
         check("steer_oe", 32'(pt_oe[1]), 32'(v | c[0]));
         check("steer_out", 32'(pt_out[1]), 32'(v ? c[3] : c[0]));
      end
      end_test("pulse_priority");
      // Port M: direction, wired-OR, pull enable, polarity, data
      for (i = 0; i < 32; i++) begin
         {d, w, p, s, v} = 5'(i);
         apb(1'b1, a_pmr, d ? 32'h0000003f : 32'h00000000);
         apb(1'b1, a_od, w ? 32'h0000003f : 32'h00000000);
         apb(1'b1, a_pe, p ? 32'h0000003f : 32'h00000000);
         apb(1'b1, a_pol, s ? 32'h0000003f : 32'h00000000);
         apb(1'b1, a_pmd, v ? 32'h0000003f : 32'h00000000);
         repeat (3) @(posedge clk);
         check("pm_pull_up", 32'(pm_pu), 32'({6{p & ~s & (~d | w)}}));
         check("pm_pull_down", 32'(pm_pd), 32'({6{p & s & ~d}}));
         check("pm_oe", 32'(pm_oe), 32'({6{d & ~(w & v)}}));
         check("pm_out", 32'(pm_out & pm_oe), 32'({6{d & ~w & v}}));
         // A pin that is neither output nor pulled floats, so it is skipped
         if (d | p)
            rdc("pm_data_rd", a_pmd, 32'({6{d ? v : ~s}}));
      end
      end_test("port_m_pins");
      test_done;
   end
endmodule // tb_ptm_pin_control
